// ===== logic/nvm_pkg.sv
// package: address map, program register layout and shared types for the nvm control block
package nvm_pkg;

	localparam logic [12:0] PROG_REG_ADDR = 13'h001c;
	localparam logic [12:0] PAGE0_LO = 13'h0020;
	localparam logic [12:0] PAGE0_HI = 13'h004f;
	localparam logic [12:0] MAIN_A_LO = 13'h0100;
	localparam logic [12:0] MAIN_A_HI = 13'h09ff;
	localparam logic [12:0] MAIN_B_LO = 13'h0a00;
	localparam logic [12:0] MAIN_B_HI = 13'h10ff;
	localparam logic [12:0] VECT_LO = 13'h1ff0;
	localparam logic [12:0] VECT_HI = 13'h1fff;
	localparam int GENERAL_BYTES = 4144;
	localparam int PAGE0_BYTES = 48;
	localparam int VECTOR_BYTES = 16;

	localparam int BIT_WRITE_ENABLE = 6;
	localparam int BIT_ERASE = 3;
	localparam int BIT_LATCH_A = 2;
	localparam int BIT_LATCH_B = 1;
	localparam int BIT_HIGH_VOLTAGE = 0;
	localparam logic [7:0] PROG_REG_RESET = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// latched programming buses of one array
	typedef struct packed {
		logic latched;
		logic [12:0] addr;
		logic [7:0] data;
	} array_latch_t;

	typedef struct packed {
		logic write_enable;
		logic erase;
		logic latch_a;
		logic latch_b;
		logic high_voltage;
	} prog_ctrl_t;

endpackage

// ===== logic/nvm_array_port.sv
// module: one array's programming latch, cell store and program/erase engine
module nvm_array_port #(
	parameter int BYTES = 2048
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic latch_en,
	input wire logic hit,
	input wire logic wr,
	input wire logic [12:0] addr,
	input wire logic [$clog2(BYTES)-1:0] index,
	input wire logic [7:0] wdata,
	input wire logic hv_on,
	input wire logic erase,
	output logic [7:0] rdata,
	output nvm_pkg::array_latch_t lat
);
	////////////////////////////////////////////////////////////////////////////////
	// cells are not reset: the store is nonvolatile
	logic [7:0] cells [BYTES];
	logic [$clog2(BYTES)-1:0] lat_index_ff;
	nvm_pkg::array_latch_t lat_ff;
	nvm_pkg::array_latch_t nxt_lat;

	assign lat = lat_ff;
	assign rdata = cells[index];

	always_comb begin
		nxt_lat = lat_ff;
		if (!latch_en) begin
			nxt_lat.latched = 1'b0;
		end else if (hit && wr && !lat_ff.latched) begin
			// only the first write after latching is captured
			nxt_lat.latched = 1'b1;
			nxt_lat.addr = addr;
			nxt_lat.data = wdata;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lat_ff <= '0;
			lat_index_ff <= '0;
		end else begin
			lat_ff <= nxt_lat;
			if (latch_en && hit && wr && !lat_ff.latched) begin
				lat_index_ff <= index;
			end
		end
	end

	// cell update while voltage is applied; real timing is left to software
	always_ff @(posedge CLK) begin
		if (hv_on && lat_ff.latched) begin
			if (erase) begin
				for (int i = 0; i < BYTES; i++) begin
					cells[i] <= nvm_pkg::ERASED_BYTE;
				end
			end else begin
				cells[lat_index_ff] <= cells[lat_index_ff] & lat_ff.data;
			end
		end
	end
endmodule // nvm_array_port

// ===== logic/nvm_program_control.sv
// module: top of the nvm program control with register port and two arrays
//
// The implementer's own choice: strobed register access.
module nvm_program_control (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [12:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic HIT,
	output logic HV_A,
	output logic HV_B,
	output logic ERASE_MODE
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		nvm_pkg::prog_ctrl_t ctrl;
		logic [7:0] rdata;
		logic hit;
		logic hv_a;
		logic hv_b;
		logic erase_mode;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	logic in_page0, in_a_main, in_b_main, in_vect, hit_a, hit_b, hit_reg;
	logic [11:0] idx_a;
	logic [10:0] idx_b;
	logic [12:0] off_a, off_b;
	logic [7:0] rd_a, rd_b, reg_view;
	nvm_pkg::array_latch_t lat_a, lat_b;
	logic wr_a, wr_b;

	////////////////////////////////////////////////////////////////////////////////
	// decode
	assign in_page0 = ADDR >= nvm_pkg::PAGE0_LO && ADDR <= nvm_pkg::PAGE0_HI;
	assign in_a_main = ADDR >= nvm_pkg::MAIN_A_LO && ADDR <= nvm_pkg::MAIN_A_HI;
	assign in_b_main = ADDR >= nvm_pkg::MAIN_B_LO && ADDR <= nvm_pkg::MAIN_B_HI;
	assign in_vect = ADDR >= nvm_pkg::VECT_LO && ADDR <= nvm_pkg::VECT_HI;
	assign hit_a = in_page0 || in_a_main;
	assign hit_b = in_b_main || in_vect;
	assign hit_reg = ADDR == nvm_pkg::PROG_REG_ADDR;

	// array a: page zero at 0..47, main at 48..2351; array b: main 0..1791, vectors after
	always_comb begin
		off_a = in_page0 ? (ADDR - nvm_pkg::PAGE0_LO)
			: 13'(ADDR - nvm_pkg::MAIN_A_LO + 13'(nvm_pkg::PAGE0_BYTES));
		off_b = in_vect ? 13'(ADDR - nvm_pkg::VECT_LO + (nvm_pkg::MAIN_B_HI - nvm_pkg::MAIN_B_LO)
			+ 13'h0001) : (ADDR - nvm_pkg::MAIN_B_LO);
	end
	assign idx_a = off_a[11:0];
	assign idx_b = off_b[10:0];

	// array writes reach the latch only when enabled; otherwise plain writes are ignored
	assign wr_a = WR && hit_a && st_ff.ctrl.write_enable;
	assign wr_b = WR && hit_b && st_ff.ctrl.write_enable;

	nvm_array_port #(.BYTES(2352)) u_array_a (
		.CLK(CLK),
		.RST_N(RST_N),
		.latch_en(st_ff.ctrl.latch_a),
		.hit(hit_a),
		.wr(wr_a),
		.addr(ADDR),
		.index(idx_a),
		.wdata(WDATA),
		.hv_on(st_ff.hv_a),
		.erase(st_ff.ctrl.erase),
		.rdata(rd_a),
		.lat(lat_a)
	);

	nvm_array_port #(.BYTES(1808)) u_array_b (
		.CLK(CLK),
		.RST_N(RST_N),
		.latch_en(st_ff.ctrl.latch_b),
		.hit(hit_b),
		.wr(wr_b),
		.addr(ADDR),
		.index(idx_b),
		.wdata(WDATA),
		.hv_on(st_ff.hv_b),
		.erase(st_ff.ctrl.erase),
		.rdata(rd_b),
		.lat(lat_b)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register view; unused bits stay zero
	always_comb begin
		reg_view = 8'h00;
		reg_view[nvm_pkg::BIT_WRITE_ENABLE] = st_ff.ctrl.write_enable;
		reg_view[nvm_pkg::BIT_ERASE] = st_ff.ctrl.erase;
		reg_view[nvm_pkg::BIT_LATCH_A] = st_ff.ctrl.latch_a;
		reg_view[nvm_pkg::BIT_LATCH_B] = st_ff.ctrl.latch_b;
		reg_view[nvm_pkg::BIT_HIGH_VOLTAGE] = st_ff.ctrl.high_voltage;
	end

	always_comb begin
		nxt_st = st_ff;
		if (WR && hit_reg) begin
			nxt_st.ctrl.write_enable = WDATA[nvm_pkg::BIT_WRITE_ENABLE];
			nxt_st.ctrl.erase = WDATA[nvm_pkg::BIT_ERASE];
			nxt_st.ctrl.latch_a = WDATA[nvm_pkg::BIT_LATCH_A];
			nxt_st.ctrl.latch_b = WDATA[nvm_pkg::BIT_LATCH_B];
			// voltage only when a latched array holds a captured write
			nxt_st.ctrl.high_voltage = WDATA[nvm_pkg::BIT_HIGH_VOLTAGE] && st_ff.ctrl.write_enable
				&& ((st_ff.ctrl.latch_a && lat_a.latched)
				|| (st_ff.ctrl.latch_b && lat_b.latched));
		end
		// dropping every latch removes the voltage at once
		if (!nxt_st.ctrl.latch_a && !nxt_st.ctrl.latch_b) begin
			nxt_st.ctrl.high_voltage = 1'b0;
		end
		// a latch dropped this cycle keeps its capture until the next edge, but carries no voltage from this edge on
		nxt_st.hv_a = nxt_st.ctrl.high_voltage && nxt_st.ctrl.latch_a && st_ff.ctrl.latch_a
			&& lat_a.latched;
		nxt_st.hv_b = nxt_st.ctrl.high_voltage && nxt_st.ctrl.latch_b && st_ff.ctrl.latch_b
			&& lat_b.latched;
		nxt_st.erase_mode = nxt_st.ctrl.erase;
		nxt_st.hit = hit_a || hit_b;
		if (RD) begin
			// a latched array still reads; the other array is untouched
			nxt_st.rdata = hit_reg ? reg_view : hit_a ? rd_a : hit_b ? rd_b : 8'h00;
		end else begin
			nxt_st.rdata = 8'h00;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign RDATA = st_ff.rdata;
	assign HIT = st_ff.hit;
	assign HV_A = st_ff.hv_a;
	assign HV_B = st_ff.hv_b;
	assign ERASE_MODE = st_ff.erase_mode;

	////////////////////////////////////////////////////////////////////////////////
	property p_reg_read;
		@(posedge CLK) disable iff (!RST_N)
		RD && hit_reg |=> RDATA == {1'b0, $past(st_ff.ctrl.write_enable), 2'b00,
			$past(st_ff.ctrl.erase), $past(st_ff.ctrl.latch_a), $past(st_ff.ctrl.latch_b),
			$past(st_ff.ctrl.high_voltage)};
	endproperty
	a_reg_read: assert property (p_reg_read) else $error("register read mismatch");

	property p_reserved_zero;
		@(posedge CLK) disable iff (!RST_N)
		RD && hit_reg |=> RDATA[7] == 1'b0 && RDATA[5:4] == 2'b00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_hv_needs_latch;
		@(posedge CLK) disable iff (!RST_N)
		st_ff.ctrl.high_voltage |-> st_ff.ctrl.latch_a || st_ff.ctrl.latch_b;
	endproperty
	a_hv_needs_latch: assert property (p_hv_needs_latch) else $error("voltage without latch");

	property p_hv_a_cause;
		@(posedge CLK) disable iff (!RST_N)
		HV_A |-> st_ff.ctrl.latch_a && lat_a.latched;
	endproperty
	a_hv_a_cause: assert property (p_hv_a_cause) else $error("array a voltage unlatched");

	property p_we_write;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg |=> st_ff.ctrl.write_enable == $past(WDATA[6]);
	endproperty
	a_we_write: assert property (p_we_write) else $error("write enable not stored");

	property p_erase_write;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg |=> ERASE_MODE == $past(WDATA[3]);
	endproperty
	a_erase_write: assert property (p_erase_write) else $error("erase select lost");

	property p_latch_hold;
		@(posedge CLK) disable iff (!RST_N)
		lat_a.latched && st_ff.ctrl.latch_a |=> lat_a.latched && $stable(lat_a.addr);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("array a latch moved");

	property p_latch_b_drop;
		@(posedge CLK) disable iff (!RST_N)
		!st_ff.ctrl.latch_b |=> !lat_b.latched;
	endproperty
	a_latch_b_drop: assert property (p_latch_b_drop) else $error("array b latch stuck");

	property p_latch_a_write;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg |=> st_ff.ctrl.latch_a == $past(WDATA[2]);
	endproperty
	a_latch_a_write: assert property (p_latch_a_write) else $error("latch a select lost");

	property p_latch_b_write;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg |=> st_ff.ctrl.latch_b == $past(WDATA[1]);
	endproperty
	a_latch_b_write: assert property (p_latch_b_write) else $error("latch b select lost");

	property p_erase_stored;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg |=> st_ff.ctrl.erase == $past(WDATA[3]);
	endproperty
	a_erase_stored: assert property (p_erase_stored) else $error("erase bit not stored");

	property p_hv_refused_we;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg && !st_ff.ctrl.write_enable |=> !st_ff.ctrl.high_voltage;
	endproperty
	a_hv_refused_we: assert property (p_hv_refused_we) else $error("voltage without enable");

	property p_hv_refused_unlatched;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg && !lat_a.latched && !lat_b.latched |=> !st_ff.ctrl.high_voltage;
	endproperty
	a_hv_refused_unlatched: assert property (p_hv_refused_unlatched) else $error("voltage no write");

	property p_hv_set;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg && WDATA[0] && WDATA[2] && st_ff.ctrl.write_enable && st_ff.ctrl.latch_a
			&& lat_a.latched |=> st_ff.ctrl.high_voltage && HV_A;
	endproperty
	a_hv_set: assert property (p_hv_set) else $error("voltage not applied");

	property p_hv_drop;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg && !WDATA[0] |=> !st_ff.ctrl.high_voltage;
	endproperty
	a_hv_drop: assert property (p_hv_drop) else $error("voltage not removed");

	property p_hv_drop_latch;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_reg && !WDATA[2] && !WDATA[1] |=> !HV_A && !HV_B;
	endproperty
	a_hv_drop_latch: assert property (p_hv_drop_latch) else $error("voltage after unlatch");

	property p_hv_stands;
		@(posedge CLK) disable iff (!RST_N)
		!(WR && hit_reg) && st_ff.ctrl.high_voltage |=> st_ff.ctrl.high_voltage;
	endproperty
	a_hv_stands: assert property (p_hv_stands) else $error("voltage dropped alone");

	property p_ctrl_stands;
		@(posedge CLK) disable iff (!RST_N)
		!(WR && hit_reg) |=> $stable(st_ff.ctrl.write_enable) && $stable(st_ff.ctrl.erase)
			&& $stable(st_ff.ctrl.latch_a) && $stable(st_ff.ctrl.latch_b);
	endproperty
	a_ctrl_stands: assert property (p_ctrl_stands) else $error("control bits moved");

	property p_hv_b_cause;
		@(posedge CLK) disable iff (!RST_N)
		HV_B |-> st_ff.ctrl.latch_b && lat_b.latched;
	endproperty
	a_hv_b_cause: assert property (p_hv_b_cause) else $error("array b voltage unlatched");

	property p_hv_a_on;
		@(posedge CLK) disable iff (!RST_N)
		HV_A |-> st_ff.ctrl.high_voltage;
	endproperty
	a_hv_a_on: assert property (p_hv_a_on) else $error("array a voltage without bit");

	property p_rdata_idle;
		@(posedge CLK) disable iff (!RST_N)
		!RD |=> RDATA == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

	property p_below_store;
		@(posedge CLK) disable iff (!RST_N)
		ADDR < nvm_pkg::PAGE0_LO |=> !HIT;
	endproperty
	a_below_store: assert property (p_below_store) else $error("hit below store");

	property p_page0_gap;
		@(posedge CLK) disable iff (!RST_N)
		ADDR > nvm_pkg::PAGE0_HI && ADDR < nvm_pkg::MAIN_A_LO |=> !HIT;
	endproperty
	a_page0_gap: assert property (p_page0_gap) else $error("hit in page zero gap");

	property p_upper_gap;
		@(posedge CLK) disable iff (!RST_N)
		ADDR > nvm_pkg::MAIN_B_HI && ADDR < nvm_pkg::VECT_LO |=> !HIT;
	endproperty
	a_upper_gap: assert property (p_upper_gap) else $error("hit in upper gap");

	property p_vector_hit;
		@(posedge CLK) disable iff (!RST_N)
		ADDR >= nvm_pkg::VECT_LO |=> HIT;
	endproperty
	a_vector_hit: assert property (p_vector_hit) else $error("vector not in store");

	property p_arrays_apart;
		@(posedge CLK) disable iff (!RST_N)
		!(hit_a && hit_b);
	endproperty
	a_arrays_apart: assert property (p_arrays_apart) else $error("both arrays hit");

	property p_split_point;
		@(posedge CLK) disable iff (!RST_N)
		ADDR >= nvm_pkg::MAIN_B_LO && ADDR <= nvm_pkg::MAIN_B_HI |-> hit_b && !hit_a;
	endproperty
	a_split_point: assert property (p_split_point) else $error("array b range misrouted");

	property p_idx_a_range;
		@(posedge CLK) disable iff (!RST_N)
		hit_a |-> idx_a < 12'd2352;
	endproperty
	a_idx_a_range: assert property (p_idx_a_range) else $error("array a index out of range");

	property p_idx_b_range;
		@(posedge CLK) disable iff (!RST_N)
		hit_b |-> idx_b < 11'd1808;
	endproperty
	a_idx_b_range: assert property (p_idx_b_range) else $error("array b index out of range");

	property p_latch_a_drop;
		@(posedge CLK) disable iff (!RST_N)
		!st_ff.ctrl.latch_a |=> !lat_a.latched;
	endproperty
	a_latch_a_drop: assert property (p_latch_a_drop) else $error("array a latch stuck");

	property p_latch_b_hold;
		@(posedge CLK) disable iff (!RST_N)
		lat_b.latched && st_ff.ctrl.latch_b |=> lat_b.latched && $stable(lat_b.addr);
	endproperty
	a_latch_b_hold: assert property (p_latch_b_hold) else $error("array b latch moved");

	property p_capture_a;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_a && st_ff.ctrl.write_enable && st_ff.ctrl.latch_a && !lat_a.latched
			|=> lat_a.latched && lat_a.addr == $past(ADDR) && lat_a.data == $past(WDATA);
	endproperty
	a_capture_a: assert property (p_capture_a) else $error("array a write not captured");

	property p_capture_b;
		@(posedge CLK) disable iff (!RST_N)
		WR && hit_b && st_ff.ctrl.write_enable && st_ff.ctrl.latch_b && !lat_b.latched
			|=> lat_b.latched && lat_b.addr == $past(ADDR) && lat_b.data == $past(WDATA);
	endproperty
	a_capture_b: assert property (p_capture_b) else $error("array b write not captured");

	property p_no_capture_we;
		@(posedge CLK) disable iff (!RST_N)
		!st_ff.ctrl.write_enable && !lat_a.latched |=> !lat_a.latched;
	endproperty
	a_no_capture_we: assert property (p_no_capture_we) else $error("capture without enable");

endmodule // nvm_program_control

// ===== tb/cpu_model.sv
// cpu side model: byte writes and reads on the register port
module cpu_model (
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic hit,
	output logic [12:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		addr = 13'h0000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// the strobe is dropped at the edge that takes it, so every call leaves the port idle
	task write_byte(input logic [12:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data and hit are taken only in the cycle after the strobe
	task read_byte(input logic [12:0] a, output logic [7:0] d, output logic h);
		@(posedge clk);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
		h = hit;
	endtask

	// lets the last strobe be taken, then waits for the register effects to land
	task idle;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask
endmodule // cpu_model

// ===== tb/nvm_program_control_bench.sv
// bench for the nvm program control: register, latch, voltage and decode scenarios
module nvm_program_control_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [12:0] REG = nvm_pkg::PROG_REG_ADDR;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [12:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic rd;
	logic hit;
	logic hv_a;
	logic hv_b;
	logic erase_mode;
	logic [7:0] d;
	logic h;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;

	always #10 clk = ~clk;

	nvm_program_control nvm_program_control_i (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .HIT(hit), .HV_A(hv_a),
		.HV_B(hv_b), .ERASE_MODE(erase_mode));
	cpu_model cpu_model_i (.clk(clk), .rdata(rdata), .hit(hit), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd));

	////////////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task tally_and_finish;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// the model's read task hands back settled values from the answer cycle
	task rd_chk(input string what, input logic [12:0] a, input logic [7:0] e);
		cpu_model_i.read_byte(a, d, h);
		check(what, d, e);
	endtask

	task wr_b(input logic [12:0] a, input logic [7:0] v);
		cpu_model_i.write_byte(a, v);
	endtask

	// order of the mirror: erase, voltage b, voltage a
	task hv_is(input logic [2:0] e);
		cpu_model_i.idle();
		check("mode hv", {5'h00, erase_mode, hv_b, hv_a}, {5'h00, e});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_reg_bits;
		rd_chk("reg reset", REG, 8'h00);
		hv_is(3'b000);
		wr_b(REG, 8'hff);
		rd_chk("reg ff", REG, 8'h4e);
		hv_is(3'b100);
		wr_b(REG, 8'h00);
		rd_chk("reg cleared", REG, 8'h00);
	endtask

	// voltage refused without enable, and when the latched array took no write
	task t_refuse;
		wr_b(REG, 8'h04);
		wr_b(13'h0123, 8'h00);
		wr_b(REG, 8'h05);
		hv_is(3'b000);
		wr_b(REG, 8'h42);
		wr_b(13'h0123, 8'h00);
		wr_b(REG, 8'h43);
		hv_is(3'b000);
		wr_b(REG, 8'h00);
	endtask

	task t_erase_program;
		wr_b(REG, 8'h4c);
		wr_b(13'h0123, 8'h00);
		wr_b(REG, 8'h4d);
		hv_is(3'b101);
		wr_b(REG, 8'h4c);
		wr_b(REG, 8'h40);
		rd_chk("erased cell", 13'h0123, 8'hff);
		wr_b(REG, 8'h44);
		wr_b(13'h0123, 8'h5a);
		wr_b(13'h0123, 8'ha5);
		wr_b(REG, 8'h45);
		hv_is(3'b001);
		wr_b(REG, 8'h44);
		wr_b(REG, 8'h40);
		rd_chk("programmed cell", 13'h0123, 8'h5a);
		wr_b(REG, 8'h00);
	endtask

	// no program time is waited: the store acts at once
	task t_erase_both;
		wr_b(REG, 8'h4e);
		wr_b(13'h0123, 8'h00);
		wr_b(13'h0a00, 8'h00);
		wr_b(REG, 8'h4f);
		hv_is(3'b111);
		wr_b(REG, 8'h4e);
		wr_b(REG, 8'h40);
		rd_chk("array b erased", 13'h0a00, 8'hff);
		rd_chk("array a erased", 13'h0123, 8'hff);
		wr_b(REG, 8'h00);
	endtask

	// a reset in mid-run clears every control bit
	task t_reset;
		wr_b(REG, 8'h4e);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk("reg after reset", REG, 8'h00);
		hv_is(3'b000);
	endtask

	task t_decode;
		logic [12:0] a[10];
		logic [9:0] e;
		a = '{13'h001f, 13'h0020, 13'h004f, 13'h0050, 13'h00ff,
			13'h0100, 13'h10ff, 13'h1100, 13'h1ff0, 13'h1fff};
		e = 10'b0110011011;
		for (int i = 0; i < 10; i++) begin
			cpu_model_i.read_byte(a[i], d, h);
			check("hit", {7'h00, h}, {7'h00, e[9 - i]});
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reg_bits();
		t_refuse();
		t_erase_program();
		t_erase_both();
		t_reset();
		t_decode();
		cpu_model_i.idle();
		tally_and_finish();
	end
endmodule // nvm_program_control_bench
